// ==== logic/lbc_local_bus_control.sv ====
// local bus arbiter, strobe, wait-state, transceiver and memory decode logic
// assumes synchronous inputs and an axi4-lite master
//
// Overview of operation
// - processor, dma and refresh request the local bus
// - one local owner at a time; system access also holds the arbiter
// - priority dma, then refresh, then processor
// - processor io below 8000h goes to system bus
// - system channel attention raises maskable vectored interrupt
// - only the processor drives the system bus
// - system requests pass local arbiter first
// - system transfers 8 or 16 bits
// - local strobes only while processor grant is low
// - status lines give io strobes, memory cycle, write line; data strobe follows processor grant alone
// - wait states only for processor local cycles
// - ram one, prom two, serial write one, serial read three waits
// - serial access extended while recovery wait
// - interrupt acknowledge: first two waits, vector cycle one
// - byte swap only for dma odd memory to io
// - ram write enable held through write cycle
// - column strobes: even, odd, or both for words
// - boot fetch lands at top of prom
// - byte parity error while ram write enable is high raises non-maskable interrupt
// - cycle, write, a15-a19 pick row strobe or prom select
// - refresh grant asserts all four row strobes
// - six-bit write-only page drives system a18-a23
// - 256k window: system = cpu address - 80000h + page * 40000h
`timescale 1ns/1ps
`default_nettype none
module lbc_local_bus_control #(
	parameter int RAM_BLOCK_SHIFT = 15
) (
	input  wire logic                     core_clk_in,
	input  wire logic                     rst_in,
	input  wire logic                     clk_en_in,
	// processor cycle and acknowledge
	input  wire lbc_pkg::lbc_cpu_req_type cpu_req_in,
	output logic                          cpu_ready_out,
	output logic                          cpu_nmi_out,
	output logic                          cpu_intr_out,
	// local requesters
	input  wire logic                     dma_req_in,
	input  wire logic                     dma_done_in,
	input  wire logic                     dma_odd_io_in,
	input  wire logic                     refresh_req_in,
	input  wire logic                     refresh_done_in,
	output logic                          dma_grant_out,
	output logic                          refresh_grant_n_out,
	output logic                          processor_local_grant_n_out,
	// local strobes
	output logic                          io_read_n_out,
	output logic                          io_write_n_out,
	output logic                          local_memory_cycle_n_out,
	output logic                          local_memory_write_n_out,
	output logic                          transceiver_data_strobe_n_out,
	output logic                          byte_swap_out,
	output lbc_pkg::lbc_ram_ctl_type      ram_ctl_out,
	input  wire logic                     serial_recovery_wait_n_in,
	input  wire logic [1:0]               parity_error_in,
	// system bus side
	output logic                          sys_req_out,
	input  wire logic                     sys_done_in,
	output logic [23:0]                   sys_addr_out,
	output logic                          sys_io_out,
	output logic                          sys_wide_out,
	input  wire logic                     sys_attention_in,
	// axi4-lite slave
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready
);
	import lbc_pkg::*;

	typedef enum {ARB_IDLE, ARB_DMA, ARB_REF, ARB_CPU, ARB_SYS} lbc_arb_type;

	lbc_arb_type     arb_q;
	lbc_status_type  st;
	logic [5:0]      page_q;
	logic [1:0]      wait_q;
	logic            wait_loaded_q;
	logic            parity_q;
	logic            attn_q;
	logic            attn_en_q;
	logic            cycle_is_sys;
	logic            is_mem;
	logic            is_io;
	logic            is_serial;
	logic            in_window;
	logic            in_prom;
	logic [1:0]      wait_base;
	logic [23:0]     sys_addr_d;
	logic            aw_q;
	logic            w_q;
	logic [7:0]      awaddr_q;
	logic [31:0]     wdata_q;
	logic [3:0]      wstrb_q;

	// prom decode: upper quarter of the 1m space
	function automatic logic prom_hit(input logic [19:0] a);
		return a >= PROM_BASE;
	endfunction

	// decode of the current processor cycle
	always_comb begin
		st         = lbc_status_type'(~cpu_req_in.cycle_status_n);
		is_mem     = (st == ST_FETCH) || (st == ST_MEM_RD) || (st == ST_MEM_WR);
		is_io      = (st == ST_IO_RD) || (st == ST_IO_WR);
		in_window  = (cpu_req_in.addr >= WINDOW_BASE) && (cpu_req_in.addr <= WINDOW_TOP);
		in_prom    = prom_hit(cpu_req_in.addr);
		is_serial  = is_io && (cpu_req_in.addr[15:0] >= IO_SERIAL_LO)
			&& (cpu_req_in.addr[15:0] <= IO_SERIAL_HI);
		cycle_is_sys = (is_mem && in_window)
			|| (is_io && (cpu_req_in.addr[15:0] < IO_LOCAL_BASE));
		// per-cycle wait count
		wait_base = 2'd0;
		if (st == ST_INTA) begin
			wait_base = cpu_req_in.second_inta ? WS_INTA_2 : WS_INTA_1;
		end else if (is_mem) begin
			wait_base = in_prom ? WS_PROM : WS_RAM;
		end else if (is_serial) begin
			wait_base = (st == ST_IO_RD) ? WS_SER_RD : WS_SER_WR;
		end
		// system address through the 256k window
		sys_addr_d = {4'h0, cpu_req_in.addr} - {4'h0, WINDOW_BASE}
			+ {page_q, 18'h0_0000};
		if (is_io) begin
			sys_addr_d = {8'h00, cpu_req_in.addr[15:0]};
		end
	end

	// local arbiter: one owner, fixed priority, held until the cycle ends
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			arb_q <= ARB_IDLE;
		end else if (clk_en_in) begin
			case (arb_q)
				ARB_IDLE: begin
					if (dma_req_in) begin
						arb_q <= ARB_DMA;
					end else if (refresh_req_in) begin
						arb_q <= ARB_REF;
					end else if (cpu_req_in.valid && !cpu_ready_out
						&& st != ST_IDLE && st != ST_HALT) begin // ended cycle not retaken
						arb_q <= cycle_is_sys ? ARB_SYS : ARB_CPU;
					end
				end
				ARB_DMA: if (dma_done_in) arb_q <= ARB_IDLE;
				ARB_REF: if (refresh_done_in) arb_q <= ARB_IDLE;
				ARB_CPU: if (cpu_ready_out) arb_q <= ARB_IDLE;
				ARB_SYS: if (sys_done_in) arb_q <= ARB_IDLE;
				default: arb_q <= ARB_IDLE;
			endcase
		end
	end

	// grant outputs, one owner at a time
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			dma_grant_out               <= 1'b0;
			refresh_grant_n_out         <= 1'b1;
			processor_local_grant_n_out <= 1'b1;
		end else if (clk_en_in) begin
			dma_grant_out               <= (arb_q == ARB_DMA);
			refresh_grant_n_out         <= (arb_q != ARB_REF);
			processor_local_grant_n_out <= (arb_q != ARB_CPU);
		end
	end

	// system bus request, processor cycles only
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			sys_req_out  <= 1'b0;
			sys_addr_out <= 24'h00_0000;
			sys_io_out   <= 1'b0;
			sys_wide_out <= 1'b0;
		end else if (clk_en_in) begin
			sys_req_out  <= (arb_q == ARB_SYS) && !sys_done_in;
			sys_addr_out <= sys_addr_d;
			sys_io_out   <= is_io;
			sys_wide_out <= !cpu_req_in.bhe_n && !cpu_req_in.addr[0];
		end
	end

	// wait-state counter for processor local cycles only
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			wait_q        <= 2'd0;
			wait_loaded_q <= 1'b0;
			cpu_ready_out <= 1'b0;
		end else if (clk_en_in) begin
			cpu_ready_out <= 1'b0;
			if (arb_q != ARB_CPU || cpu_ready_out) begin
				wait_loaded_q <= 1'b0;
				cpu_ready_out <= (arb_q == ARB_SYS) && sys_done_in;
			end else if (!wait_loaded_q) begin
				wait_q        <= wait_base;
				wait_loaded_q <= 1'b1;
			end else if (wait_q != 2'd0) begin
				wait_q <= wait_q - 2'd1;
			end else if (!(is_serial && !serial_recovery_wait_n_in)) begin
				cpu_ready_out <= 1'b1;
			end
		end
	end

	// local strobes while the processor holds the bus
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			io_read_n_out                 <= 1'b1;
			io_write_n_out                <= 1'b1;
			local_memory_cycle_n_out      <= 1'b1;
			local_memory_write_n_out      <= 1'b1;
			transceiver_data_strobe_n_out <= 1'b1;
		end else if (clk_en_in) begin
			io_read_n_out  <= !(arb_q == ARB_CPU && st == ST_IO_RD);
			io_write_n_out <= !(arb_q == ARB_CPU && st == ST_IO_WR);
			local_memory_cycle_n_out <= !(arb_q == ARB_CPU && is_mem);
			local_memory_write_n_out <= !(arb_q == ARB_CPU && st == ST_MEM_WR);
			transceiver_data_strobe_n_out <= (arb_q != ARB_CPU);
		end
	end

	// transceiver, column strobes and memory decoder
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			byte_swap_out <= 1'b0;
			ram_ctl_out   <= '{row_n: 4'hF, col_n: 2'b11, we_n: 1'b1, rom_sel_n: 1'b1};
		end else if (clk_en_in) begin
			byte_swap_out <= (arb_q == ARB_DMA) && dma_odd_io_in;
			ram_ctl_out.row_n <= 4'hF;
			ram_ctl_out.col_n <= 2'b11;
			ram_ctl_out.rom_sel_n <= 1'b1;
			ram_ctl_out.we_n <= !(arb_q == ARB_CPU && st == ST_MEM_WR);
			if (arb_q == ARB_REF) begin
				ram_ctl_out.row_n <= 4'h0;
			end else if (arb_q == ARB_CPU && is_mem) begin
				if (in_prom) begin
					ram_ctl_out.rom_sel_n <= 1'b0;
				end else begin
					ram_ctl_out.row_n <= ~(4'h1 << cpu_req_in.addr[RAM_BLOCK_SHIFT +: 2]);
					ram_ctl_out.col_n <= {cpu_req_in.bhe_n, cpu_req_in.addr[0]};
				end
			end
		end
	end

	// sticky parity and attention flags; set wins over software clear
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			parity_q     <= 1'b0;
			attn_q       <= 1'b0;
			cpu_nmi_out  <= 1'b0;
			cpu_intr_out <= 1'b0;
		end else if (clk_en_in) begin
			if (|parity_error_in && !ram_ctl_out.we_n == 1'b0) begin
				parity_q <= 1'b1;
			end else if (aw_q && w_q && awaddr_q == OFS_CTRL && wdata_q[CT_PAR_CLR_BIT]) begin
				parity_q <= 1'b0;
			end
			if (sys_attention_in) begin
				attn_q <= 1'b1;
			end else if (aw_q && w_q && awaddr_q == OFS_CTRL && wdata_q[CT_ATTN_CLR_BIT]) begin
				attn_q <= 1'b0;
			end
			cpu_nmi_out  <= parity_q;
			cpu_intr_out <= attn_q && attn_en_q;
		end
	end

	// axi4-lite write path: address and data latched in either order
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			aw_q          <= 1'b0;
			w_q           <= 1'b0;
			awaddr_q      <= 8'h00;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			page_q        <= PAGE_RESET;
			attn_en_q     <= 1'b0;
		end else if (clk_en_in) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (aw_q && w_q) begin
				aw_q         <= 1'b0;
				w_q          <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q == OFS_PAGE || awaddr_q == OFS_CTRL)
					? RESP_OKAY : RESP_SLVERR;
				if (awaddr_q == OFS_PAGE && wstrb_q[0]) begin
					page_q <= wdata_q[5:0];
				end
				if (awaddr_q == OFS_CTRL && wstrb_q[0]) begin
					attn_en_q <= wdata_q[CT_ATTN_EN_BIT];
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// write-channel readies: one write under way at a time
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else if (clk_en_in) begin
			s_axi_awready <= !aw_q && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_q && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
		end
	end

	// axi4-lite read path; write-only page reads zero
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (clk_en_in) begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				s_axi_rdata  <= 32'h0000_0000;
				case (s_axi_araddr)
					OFS_PAGE: s_axi_rdata <= 32'h0000_0000;
					OFS_STATUS: begin
						s_axi_rdata[ST_OWNER_LSB +: 2] <= (arb_q == ARB_DMA) ? OWN_DMA
							: (arb_q == ARB_REF) ? OWN_REF
							: (arb_q == ARB_CPU) ? OWN_CPU : OWN_NONE;
						s_axi_rdata[ST_PARITY_BIT] <= parity_q;
						s_axi_rdata[ST_ATTN_BIT]   <= attn_q;
						s_axi_rdata[ST_SYS_BIT]    <= (arb_q == ARB_SYS);
					end
					OFS_CTRL: s_axi_rdata[CT_ATTN_EN_BIT] <= attn_en_q;
					default: s_axi_rresp <= RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ==== logic/lbc_pkg.sv ====
// local bus control package: register map, encodings, wait counts
// assumes a single clock domain and an axi4-lite register port
package lbc_pkg;

	// axi4-lite register offsets (byte addresses)
	localparam logic [7:0] OFS_PAGE      = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_CTRL      = 8'h08;
	// status field positions
	localparam int ST_OWNER_LSB  = 0;
	localparam int ST_PARITY_BIT = 2;
	localparam int ST_ATTN_BIT   = 3;
	localparam int ST_SYS_BIT    = 4;
	// control field positions
	localparam int CT_ATTN_EN_BIT = 0;
	localparam int CT_PAR_CLR_BIT = 1;
	localparam int CT_ATTN_CLR_BIT = 2;
	// reset values and response codes
	localparam logic [5:0] PAGE_RESET = 6'h00;
	localparam logic [1:0] RESP_OKAY  = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// processor window and io split
	localparam logic [19:0] WINDOW_BASE   = 20'h8_0000;
	localparam logic [19:0] WINDOW_TOP    = 20'hB_FFFF;
	localparam logic [15:0] IO_LOCAL_BASE = 16'h8000;
	localparam logic [15:0] IO_SERIAL_LO  = 16'h8110;
	localparam logic [15:0] IO_SERIAL_HI  = 16'h815F;
	localparam logic [19:0] BOOT_FETCH    = 20'hF_FFF0;
	localparam logic [19:0] PROM_BASE     = 20'hC_0000;

	// wait state counts
	localparam logic [1:0] WS_RAM       = 2'd1;
	localparam logic [1:0] WS_PROM      = 2'd2;
	localparam logic [1:0] WS_SER_WR    = 2'd1;
	localparam logic [1:0] WS_SER_RD    = 2'd3;
	localparam logic [1:0] WS_INTA_1    = 2'd2;
	localparam logic [1:0] WS_INTA_2    = 2'd1;

	// decoded processor status (active-low lines inverted)
	typedef enum logic [2:0] {
		ST_INTA = 3'd0, ST_IO_RD = 3'd1, ST_IO_WR = 3'd2, ST_HALT = 3'd3,
		ST_FETCH = 3'd4, ST_MEM_RD = 3'd5, ST_MEM_WR = 3'd6, ST_IDLE = 3'd7
	} lbc_status_type;

	typedef enum logic [1:0] {
		OWN_NONE = 2'd0, OWN_DMA = 2'd1, OWN_REF = 2'd2, OWN_CPU = 2'd3
	} lbc_owner_type;

	// processor cycle request
	typedef struct packed {
		logic        valid;
		logic [2:0]  cycle_status_n;
		logic [19:0] addr;
		logic        bhe_n;
		logic        second_inta;
	} lbc_cpu_req_type;

	// ram strobes toward local memory
	typedef struct packed {
		logic [3:0] row_n;
		logic [1:0] col_n;
		logic       we_n;
		logic       rom_sel_n;
	} lbc_ram_ctl_type;

endpackage

// ==== sim/lbc_far_end.sv ====
// far end: processor core and system bus arbiter
// assumes ready pulses once per cycle
`timescale 1ns/1ps
`default_nettype none
module lbc_far_end (
	input  wire logic                   clk_in,
	input  wire logic                   rst_in,
	input  wire logic                   go_in,
	input  wire logic [2:0]             code_in,
	input  wire logic [19:0]            addr_in,
	input  wire logic                   bhe_n_in,
	input  wire logic                   second_in,
	input  wire logic [3:0]             sys_lag_in,
	input  wire logic                   cpu_ready_in,
	input  wire logic                   sys_req_in,
	output var lbc_pkg::lbc_cpu_req_type cpu_req_out,
	output logic                        done_out,
	output logic [7:0]                  lat_out,
	output logic                        sys_done_out
);
	import lbc_pkg::*;
	logic [3:0] sys_cnt_q;
	logic       sys_wait_q;
	// processor: hold the cycle until ready, then release the lines
	always_ff @(posedge clk_in) begin
		done_out <= 1'b0;
		if (rst_in) begin
			cpu_req_out <= {1'b0, 3'h0, 20'h0_0000, 1'b1, 1'b0};
			lat_out <= 8'h00;
		end else if (cpu_req_out.valid) begin
			if (cpu_ready_in) begin
				cpu_req_out.valid <= 1'b0;
				cpu_req_out.addr <= ~cpu_req_out.addr; // released lines keep no value
				cpu_req_out.cycle_status_n <= 3'h0; // idle status
				done_out <= 1'b1;
			end else begin
				lat_out <= lat_out + 8'h01;
			end
		end else if (go_in) begin
			cpu_req_out <= {1'b1, ~code_in, addr_in, bhe_n_in, second_in};
			lat_out <= 8'h00;
		end
	end
	// system arbiter: answer a passed-on request after a chosen lag
	always_ff @(posedge clk_in) begin
		sys_done_out <= 1'b0;
		if (rst_in || !sys_req_in) begin
			sys_cnt_q <= 4'h0;
			sys_wait_q <= 1'b0;
		end else if (!sys_wait_q) begin
			sys_cnt_q <= sys_cnt_q + 4'h1;
			if (sys_cnt_q == sys_lag_in) begin
				sys_done_out <= 1'b1;
				sys_wait_q <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== sim/lbc_properties.sv ====
// checker: arbiter, strobes, waits, system window
// sees only the top module's ports; bound to every instance of it
`timescale 1ns/1ps
`default_nettype none
module lbc_properties (
	input wire logic                     core_clk_in,
	input wire logic                     rst_in,
	input wire lbc_pkg::lbc_cpu_req_type cpu_req_in,
	input wire logic                     cpu_ready_out,
	input wire logic                     cpu_nmi_out,
	input wire logic [1:0]               parity_error_in,
	input wire logic                     dma_grant_out,
	input wire logic                     dma_done_in,
	input wire logic                     refresh_grant_n_out,
	input wire logic                     processor_local_grant_n_out,
	input wire logic                     io_read_n_out,
	input wire logic                     io_write_n_out,
	input wire logic                     local_memory_cycle_n_out,
	input wire logic                     local_memory_write_n_out,
	input wire lbc_pkg::lbc_ram_ctl_type ram_ctl_out,
	input wire logic                     sys_req_out,
	input wire logic [23:0]              sys_addr_out,
	input wire logic                     sys_io_out
);
	import lbc_pkg::*;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// any strobe
	logic strobe_on;
	assign strobe_on = !(io_read_n_out && io_write_n_out && local_memory_cycle_n_out);
	// one or two wait states
	sequence s_one_wait;
		!cpu_ready_out ##1 !cpu_ready_out ##1 cpu_ready_out;
	endsequence
	sequence s_two_waits;
		!cpu_ready_out [*3] ##1 cpu_ready_out;
	endsequence
	a_one_owner: assert property (
		$onehot0({dma_grant_out, !refresh_grant_n_out, !processor_local_grant_n_out}))
		else $error("two owners");
	a_strobe_grant: assert property (strobe_on |-> !processor_local_grant_n_out)
		else $error("strobe without grant");
	a_ram_waits: assert property (
		$fell(local_memory_cycle_n_out) && ram_ctl_out.rom_sel_n |-> s_one_wait)
		else $error("ram waits");
	a_prom_waits: assert property (
		$fell(local_memory_cycle_n_out) && !ram_ctl_out.rom_sel_n |-> s_two_waits)
		else $error("prom waits");
	a_write_enable: assert property (
		!local_memory_cycle_n_out && !local_memory_write_n_out && ram_ctl_out.rom_sel_n
		|-> !ram_ctl_out.we_n)
		else $error("write enable dropped");
	a_refresh_rows: assert property (
		!refresh_grant_n_out |-> ##[0:1] ram_ctl_out.row_n == 4'h0)
		else $error("refresh rows");
	a_grant_held: assert property (
		dma_grant_out && !dma_done_in && !$past(dma_done_in) |=> dma_grant_out)
		else $error("dma grant lost");
	a_parity_nmi: assert property (|parity_error_in |-> ##[1:2] cpu_nmi_out)
		else $error("no nmi");
	a_sys_window: assert property (
		sys_req_out && !sys_io_out && cpu_req_in.valid
		|-> sys_addr_out[17:0] == cpu_req_in.addr[17:0])
		else $error("window offset");
	a_sys_io_low: assert property (sys_req_out && sys_io_out |-> !sys_addr_out[15])
		else $error("high io to system");
endmodule
bind lbc_local_bus_control lbc_properties u_props (.*);
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench for the local bus control block
// far end plays processor and system arbiter; registers over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import lbc_pkg::*;
	typedef struct packed {
		logic [2:0]  code;
		logic [19:0] addr;
		logic        bhe;
		logic        sec;
		logic [7:0]  lat;
		logic [7:0]  exp;
		logic [7:0]  mask;
		logic [23:0] sa;
	} lbc_row_type;
	// flags: io rd, io wr, mem, mem wr, rom, system, odd col, even col
	lbc_row_type rows [12] = '{
		'{3'h5, 20'h0_1000, 1'b0, 1'b0, 8'h04, 8'h23, 8'hFF, 24'h00_0000},
		'{3'h6, 20'h0_2001, 1'b0, 1'b0, 8'h04, 8'h32, 8'hFF, 24'h00_0000},
		'{3'h5, 20'h0_3000, 1'b1, 1'b0, 8'h04, 8'h21, 8'hFF, 24'h00_0000},
		'{3'h4, 20'hF_FFF0, 1'b0, 1'b0, 8'h05, 8'h28, 8'hFC, 24'h00_0000},
		'{3'h2, 20'h0_8110, 1'b1, 1'b0, 8'h04, 8'h40, 8'hEC, 24'h00_0000},
		'{3'h1, 20'h0_815F, 1'b1, 1'b0, 8'h06, 8'h80, 8'hEC, 24'h00_0000},
		'{3'h1, 20'h0_8000, 1'b1, 1'b0, 8'h00, 8'h80, 8'hEC, 24'h00_0000},
		'{3'h0, 20'h0_0000, 1'b1, 1'b0, 8'h05, 8'h00, 8'h00, 24'h00_0000},
		'{3'h0, 20'h0_0000, 1'b1, 1'b1, 8'h04, 8'h00, 8'h00, 24'h00_0000},
		'{3'h2, 20'h0_7FFF, 1'b1, 1'b0, 8'h00, 8'h04, 8'hEC, 24'h00_0000},
		'{3'h5, 20'h8_1000, 1'b1, 1'b0, 8'h00, 8'h04, 8'hEC, 24'h0C_1000},
		'{3'h6, 20'h8_2000, 1'b0, 1'b0, 8'h00, 8'h04, 8'hEC, 24'h0C_2000}};
	logic        core_clk_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1, go = 1'b0, clr = 1'b0;
	logic        dma_req_in = 1'b0, dma_done_in = 1'b0, dma_odd_io_in = 1'b0, bhe = 1'b1;
	logic        refresh_req_in = 1'b0, refresh_done_in = 1'b0, sys_attention_in = 1'b0;
	logic        serial_recovery_wait_n_in = 1'b1, sec = 1'b0, done, cap_io, cap_wide;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, sys_req_out, sys_done_in;
	logic        cpu_ready_out, cpu_nmi_out, cpu_intr_out, dma_grant_out, refresh_grant_n_out;
	logic        processor_local_grant_n_out, io_read_n_out, io_write_n_out, byte_swap_out;
	logic        local_memory_cycle_n_out, local_memory_write_n_out, sys_io_out, sys_wide_out;
	logic        transceiver_data_strobe_n_out;
	logic [1:0]  parity_error_in = 2'h0, resp, s_axi_bresp, s_axi_rresp;
	logic [2:0]  code = 3'h7;
	logic [3:0]  lag = 4'h1, s_axi_wstrb = 4'hF;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lat, seen;
	logic [19:0] addr = 20'h0_0000;
	logic [23:0] sys_addr_out, cap_addr;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
	lbc_cpu_req_type cpu_req_in;
	lbc_ram_ctl_type ram_ctl_out;
	int          n_errors = 0, comparisons = 0;
	always #2 core_clk_in = ~core_clk_in;
	lbc_local_bus_control dut (.*);
	lbc_far_end u_far (.clk_in(core_clk_in), .rst_in, .go_in(go), .code_in(code), .addr_in(addr),
		.bhe_n_in(bhe), .second_in(sec), .sys_lag_in(lag), .cpu_ready_in(cpu_ready_out),
		.sys_req_in(sys_req_out), .cpu_req_out(cpu_req_in), .done_out(done), .lat_out(lat),
		.sys_done_out(sys_done_in));
	// strobes seen in one cycle
	always @(posedge core_clk_in) begin
		if (clr)
			seen <= 8'h00;
		else
			seen <= seen | {!io_read_n_out, !io_write_n_out, !local_memory_cycle_n_out,
				!local_memory_write_n_out, !ram_ctl_out.rom_sel_n, sys_req_out, ~ram_ctl_out.col_n};
		if (sys_req_out)
			{cap_addr, cap_io, cap_wide} <= {sys_addr_out, sys_io_out, sys_wide_out};
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
		comparisons++;
		if (got !== want) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask
	task automatic cyc(input logic [2:0] c, input logic [19:0] a, input logic b, input logic s);
		{code, addr, bhe, sec, go, clr} <= {c, a, b, s, 2'b11};
		@(posedge core_clk_in);
		{go, clr} <= 2'b00;
		do @(posedge core_clk_in); while (done !== 1'b1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge core_clk_in);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		tick(1);
	endtask
	task automatic rd_reg(input logic [7:0] a);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		do begin
			@(posedge core_clk_in);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		{rd, resp} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
		tick(1);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// hang guard
	initial begin
		tick(20000);
		n_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		tally_and_finish;
	end
	// main sequence
	initial begin
		tick(6);
		rst_in <= 1'b0;
		wr(OFS_PAGE, 32'h0000_0003);
		foreach (rows[i]) begin
			lag <= i[3:0];
			cyc(rows[i].code, rows[i].addr, rows[i].bhe, rows[i].sec);
			if (rows[i].lat != 8'h00) chk(lat, rows[i].lat, "wait count");
			chk(seen & rows[i].mask, rows[i].exp, "strobes");
			if (rows[i].exp[2]) chk({cap_io, cap_wide}, {rows[i].code inside {3'h1, 3'h2},
				!rows[i].bhe && !rows[i].addr[0]}, "system kind");
			if (rows[i].sa != 24'h00_0000) chk(cap_addr, rows[i].sa, "system address");
			$display("row %0d done", i);
		end
		{dma_req_in, refresh_req_in, dma_odd_io_in} <= 3'b111;
		fork
			cyc(3'h5, 20'h0_1000, 1'b0, 1'b0);
			begin
				do @(posedge core_clk_in); while (dma_grant_out !== 1'b1);
				tick(2);
				chk({refresh_grant_n_out, processor_local_grant_n_out, byte_swap_out}, 3'h7,
					"dma owner");
				{dma_done_in, dma_req_in, dma_odd_io_in} <= 3'b100;
				tick(1);
				dma_done_in <= 1'b0;
				do @(posedge core_clk_in); while (refresh_grant_n_out !== 1'b0);
				tick(1);
				chk({processor_local_grant_n_out, ram_ctl_out.row_n}, 5'h10, "refresh");
				{refresh_done_in, refresh_req_in} <= 2'b10;
				tick(1);
				refresh_done_in <= 1'b0;
			end
		join
		$display("priority test done");
		fork
			cyc(3'h5, 20'h0_1000, 1'b0, 1'b0);
			begin
				do @(posedge core_clk_in); while (local_memory_cycle_n_out !== 1'b0);
				parity_error_in <= 2'h2;
				tick(1);
				parity_error_in <= 2'h0;
			end
		join
		rd_reg(OFS_STATUS);
		chk({cpu_nmi_out, rd[ST_PARITY_BIT]}, 2'h3, "parity nmi");
		wr(OFS_CTRL, 32'h0000_0002);
		tick(2);
		chk(cpu_nmi_out, 1'b0, "nmi cleared");
		sys_attention_in <= 1'b1;
		tick(1);
		sys_attention_in <= 1'b0;
		tick(2);
		chk(cpu_intr_out, 1'b0, "masked attention");
		wr(OFS_CTRL, 32'h0000_0001);
		tick(2);
		chk(cpu_intr_out, 1'b1, "attention interrupt");
		wr(OFS_CTRL, 32'h0000_0005);
		tick(2);
		chk(cpu_intr_out, 1'b0, "attention cleared");
		$display("interrupt test done");
		serial_recovery_wait_n_in <= 1'b0;
		fork
			cyc(3'h1, 20'h0_8120, 1'b1, 1'b0);
			begin
				tick(12);
				serial_recovery_wait_n_in <= 1'b1;
			end
		join
		chk(lat > 8'h06, 1'b1, "recovery extension");
		wr(OFS_PAGE, 32'h0000_00FF);
		cyc(3'h6, 20'hB_FFFE, 1'b0, 1'b0);
		chk(cap_addr, 24'hFF_FFFE, "page top");
		rst_in <= 1'b1;
		tick(2);
		chk({dma_grant_out, refresh_grant_n_out, processor_local_grant_n_out, cpu_nmi_out,
			cpu_intr_out}, 5'h0C, "reset outputs");
		rst_in <= 1'b0;
		rd_reg(OFS_STATUS);
		chk({rd, resp}, {32'h0000_0000, RESP_OKAY}, "status reset");
		rd_reg(OFS_CTRL);
		chk(rd, 32'h0000_0000, "control reset");
		rd_reg(OFS_PAGE);
		chk(rd, 32'h0000_0000, "page reads zero");
		rd_reg(8'h0C);
		chk(resp, RESP_SLVERR, "unmapped read");
		wr(OFS_STATUS, 32'h0000_0001);
		chk(resp, RESP_SLVERR, "status write");
		cyc(3'h5, 20'h8_1000, 1'b1, 1'b0);
		chk(cap_addr, 24'h00_1000, "page after reset");
		$display("reset test done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
